// ===== bench/return_rotate_checker.sv
// Purpose: Concurrent checks on the return and rotate execution block.
// Assumes: One clock domain; sees only the top module's ports.
// Notes:   Bound to the block from the testbench top file.
`default_nettype none

module return_rotate_checker #(
    parameter int PC_W = 15
) (
    input wire logic        clk_i,               // Clock.
    input wire logic        rst_i,               // Reset.
    input wire logic        instr_valid_i,       // Offer.
    input wire logic [13:0] instr_i,             // Word.
    input wire logic [7:0]  file_rdata_i,        // File value.
    input wire logic        push_i,              // Push.
    input wire logic [PC_W-1:0] push_addr_i,     // Push address.
    input wire logic        irq_entry_i,         // Entry.
    input wire logic        status_we_i,         // Flag load.
    input wire logic [2:0]  status_wdata_i,      // Flag data.
    input wire logic        interrupt_control_we_i,    // Control load.
    input wire logic [7:0]  interrupt_control_wdata_i, // Control data.
    input wire logic        ready_o,             // Ready.
    input wire logic        done_o,              // Done.
    input wire logic        pc_load_o,           // Reload pulse.
    input wire logic [PC_W-1:0] pc_o,            // Counter.
    input wire logic [7:0]  accum_o,             // Accumulator.
    input wire logic [2:0]  status_o,            // Flags.
    input wire logic [7:0]  interrupt_control_o, // Control.
    input wire logic        file_we_o,           // Write strobe.
    input wire logic [6:0]  file_addr_o,         // Write address.
    input wire logic [7:0]  file_wdata_o         // Write data.
);
    logic take;
    logic tk_iret;
    logic tk_sret;
    logic tk_lret;
    logic tk_rl;
    logic tk_rr;
    assign take    = instr_valid_i && ready_o;
    assign tk_iret = take && instr_i == return_rotate_pkg::INTERRUPT_RETURN_OP;
    assign tk_sret = take && instr_i == return_rotate_pkg::SUBROUTINE_RETURN_OP;
    assign tk_lret = take && instr_i[13:8] == return_rotate_pkg::LITERAL_RETURN_OP;
    assign tk_rl   = take && instr_i[13:8] == return_rotate_pkg::ROTATE_LEFT_CARRY_OP;
    assign tk_rr   = take && instr_i[13:8] == return_rotate_pkg::ROTATE_RIGHT_CARRY_OP;

    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    property p_iret_timing;
        tk_iret |=> (pc_load_o && !ready_o) ##1 (done_o && ready_o && !pc_load_o);
    endproperty
    a_iret_timing: assert property (p_iret_timing) else $error("interrupt return timing wrong");
    property p_iret_irq_enable;
        tk_iret |=> interrupt_control_o[7];
    endproperty
    a_iret_irq_enable: assert property (p_iret_irq_enable) else $error("global enable not set");
    property p_sret_timing;
        tk_sret |=> (pc_load_o && !done_o) ##1 done_o;
    endproperty
    a_sret_timing: assert property (p_sret_timing) else $error("subroutine return timing wrong");
    property p_lret_accum;
        tk_lret |=> (pc_load_o && accum_o == $past(instr_i[7:0])) ##1 done_o;
    endproperty
    a_lret_accum: assert property (p_lret_accum) else $error("literal return wrong");
    property p_rl_value;
        tk_rl |=> done_o && status_o[0] == $past(file_rdata_i[7])
            && ($past(instr_i[7]) ? file_wdata_o : accum_o) == {$past(file_rdata_i[6:0]), $past(status_o[0])};
    endproperty
    a_rl_value: assert property (p_rl_value) else $error("left rotate result wrong");
    property p_rr_value;
        tk_rr |=> done_o && status_o[0] == $past(file_rdata_i[0])
            && ($past(instr_i[7]) ? file_wdata_o : accum_o) == {$past(status_o[0]), $past(file_rdata_i[7:1])};
    endproperty
    a_rr_value: assert property (p_rr_value) else $error("right rotate result wrong");
    property p_rot_dest;
        (tk_rl || tk_rr) |=> file_we_o == $past(instr_i[7])
            && (!file_we_o || (accum_o == $past(accum_o) && file_addr_o == $past(instr_i[6:0])));
    endproperty
    a_rot_dest: assert property (p_rot_dest) else $error("rotate destination wrong");
    property p_rot_flags;
        (tk_rl || tk_rr) && !status_we_i |=> status_o[2:1] == $past(status_o[2:1]);
    endproperty
    a_rot_flags: assert property (p_rot_flags) else $error("rotate changed zero or digit carry");
    property p_ret_flags;
        (tk_iret || tk_sret || tk_lret) && !status_we_i |=> $stable(status_o);
    endproperty
    a_ret_flags: assert property (p_ret_flags) else $error("return changed flags");

    c_iret: cover property (tk_iret);
    c_rl_file: cover property (tk_rl && instr_i[7]);
    c_rr_accum: cover property (tk_rr && !instr_i[7]);
endmodule : return_rotate_checker

`default_nettype wire

// ===== bench/testbench.sv
// Purpose: Self-checking bench for the return and rotate execution block.
// Assumes: Expected results are queued by the driver and matched on done_o.
// Notes:   The stack model never pops more than was pushed.
`default_nettype none

module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int PC_W = 15;
    typedef struct packed {
        logic rot; logic [7:0] accum; logic [2:0] status; logic [PC_W-1:0] pc;
        logic [7:0] irq_ctrl; logic fwe; logic [7:0] fdata; logic [6:0] faddr;
    } note_type;
    logic clk_i, rst_i, instr_valid_i, push_i, irq_entry_i, status_we_i, interrupt_control_we_i;
    logic [13:0] instr_i;
    logic [7:0] file_rdata_i, interrupt_control_wdata_i, accum_o, interrupt_control_o, file_wdata_o;
    logic [PC_W-1:0] push_addr_i, pc_o;
    logic [2:0] status_wdata_i, status_o;
    logic ready_o, done_o, pc_load_o, file_we_o;
    logic [6:0] file_addr_o;
    logic [7:0] exp_accum, exp_irq_ctrl;
    logic [2:0] exp_status;
    logic [PC_W-1:0] stk[$];
    note_type notes[$];
    note_type nt;
    int n_mismatch, cmp_count, i;
    int seed = 32'h14065C46;
    logic [31:0] r;

    return_and_rotate_exec #(.PC_W(PC_W), .STACK_DEPTH(16)) u_dut (.*);

    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    task automatic cmp_rotate(input note_type n);
        check(accum_o, n.accum);
        check(status_o, n.status);
        check(file_we_o, n.fwe);
        if (n.fwe) check(file_wdata_o, n.fdata);
        if (n.fwe) check(file_addr_o, n.faddr);
    endtask : cmp_rotate
    task automatic cmp_return(input note_type n);
        check(pc_o, n.pc);
        check(accum_o, n.accum);
        check(status_o, n.status);
        check(interrupt_control_o, n.irq_ctrl);
    endtask : cmp_return
    task automatic conclude();
        $display("Comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : conclude

    // A completion with no note behind it is itself a mismatch.
    always @(posedge clk_i) begin
        #1;
        if (rst_i === 1'b0 && done_o === 1'b1) begin
            if (notes.size() == 0) begin
                check(32'h1, 32'h0);
            end else begin
                nt = notes.pop_front();
                if (nt.rot) cmp_rotate(nt);
                else cmp_return(nt);
            end
        end
    end

    task automatic put(input logic [13:0] w, input logic [7:0] f);
        @(posedge clk_i);
        instr_valid_i <= 1'b1;
        instr_i <= w;
        file_rdata_i <= f;
    endtask : put
    task automatic idle();
        @(posedge clk_i);
        instr_valid_i <= 1'b0;
        file_rdata_i <= 8'($random(seed));
    endtask : idle
    task automatic pulse(input int which, input logic [14:0] v);
        @(posedge clk_i);
        if (which == 0) begin
            push_i <= 1'b1;
            push_addr_i <= v;
        end else if (which == 1) begin
            status_we_i <= 1'b1;
            status_wdata_i <= v[2:0];
        end else if (which == 2) begin
            interrupt_control_we_i <= 1'b1;
            interrupt_control_wdata_i <= v[7:0];
        end else begin
            irq_entry_i <= 1'b1;
        end
        @(posedge clk_i);
        {push_i, status_we_i, interrupt_control_we_i, irq_entry_i} <= 4'h0;
    endtask : pulse
    task automatic rotate(input logic left, input logic dst, input logic [6:0] a, input logic [7:0] f);
        logic [7:0] res;
        res = left ? {f[6:0], exp_status[0]} : {exp_status[0], f[7:1]};
        if (!dst) exp_accum = res;
        exp_status[0] = left ? f[7] : f[0];
        notes.push_back('{1'b1, exp_accum, exp_status, '0, exp_irq_ctrl, dst, res, a});
        put({left ? return_rotate_pkg::ROTATE_LEFT_CARRY_OP : return_rotate_pkg::ROTATE_RIGHT_CARRY_OP, dst, a}, f);
    endtask : rotate
    // A word offered straight after a return falls in the busy cycle and must be dropped.
    task automatic ret(input int kind, input logic [7:0] k, input logic refuse);
        logic [13:0] w;
        w = kind == 0 ? return_rotate_pkg::INTERRUPT_RETURN_OP :
            kind == 1 ? return_rotate_pkg::SUBROUTINE_RETURN_OP : {return_rotate_pkg::LITERAL_RETURN_OP, k};
        if (kind == 0) exp_irq_ctrl[7] = 1'b1;
        if (kind == 2) exp_accum = k;
        notes.push_back('{1'b0, exp_accum, exp_status, stk.pop_back(), exp_irq_ctrl, 1'b0, 8'h00, 7'h00});
        put(w, 8'($random(seed)));
        if (refuse) put({return_rotate_pkg::ROTATE_LEFT_CARRY_OP, 8'h80}, 8'hFF);
        idle();
    endtask : ret

    initial begin
        {instr_valid_i, push_i, irq_entry_i, status_we_i, interrupt_control_we_i} = 5'h00;
        {instr_i, file_rdata_i, push_addr_i, status_wdata_i, interrupt_control_wdata_i} = '0;
        {exp_accum, exp_irq_ctrl, exp_status} = '0;
        rst_i = 1'b1;
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        #1;
        check({ready_o, done_o, pc_load_o, file_we_o}, 32'h8);
        check({accum_o, status_o, interrupt_control_o}, 32'h0);
        check({file_addr_o, file_wdata_o, pc_o}, 32'h0);
        rotate(1'b1, 1'b0, 7'h20, 8'hE6);
        for (i = 0; i < 40; i++) begin
            r = $random(seed);
            rotate(r[0], r[1], r[8:2], r[23:16]);
            if (r[24]) begin
                idle();
                exp_status = r[27:25];
                pulse(1, {12'h000, r[27:25]});
            end
        end
        idle();
        r = $random(seed);
        exp_irq_ctrl = {1'b0, r[6:0]};
        pulse(2, {7'h00, exp_irq_ctrl});
        for (i = 0; i < 6; i++) begin
            r = $random(seed);
            stk.push_back(r[14:0]);
            pulse(0, r[14:0]);
        end
        put(14'h0000, 8'h55);
        idle();
        ret(0, 8'h00, 1'b0);
        exp_irq_ctrl[7] = 1'b0;
        pulse(3, '0);
        ret(1, 8'h00, 1'b1);
        rotate(1'b0, 1'b1, 7'h7F, 8'h01);
        idle();
        ret(2, 8'h00, 1'b0);
        ret(2, 8'hFF, 1'b1);
        ret(2, r[23:16], 1'b0);
        ret(0, 8'h00, 1'b0);
        repeat (4) @(posedge clk_i);
        check(notes.size(), 0);
        conclude();
    end

    // The whole sequence needs well under a thousand cycles.
    initial begin
        repeat (5000) @(posedge clk_i);
        n_mismatch++;
        conclude();
    end
endmodule : testbench

bind return_and_rotate_exec return_rotate_checker #(.PC_W(PC_W)) u_chk (.*);

`default_nettype wire

// ===== include/return_rotate_pkg.sv
// Purpose: Shared constants and types for the return and rotate execution block.
// Assumes: 14-bit instruction words, 8-bit data path, one instruction clock.
// Notes:   Opcode patterns here are this core's own encoding.
`default_nettype none

package return_rotate_pkg;

    localparam int INSTR_W   = 14;
    localparam int DATA_W    = 8;
    localparam int FADDR_W   = 7;
    localparam int GROUP_W   = 6;

    // Field layout of an instruction word.
    localparam int GROUP_MSB = 13;
    localparam int GROUP_LSB = 8;
    localparam int LIT_MSB   = 7;
    localparam int LIT_LSB   = 0;
    localparam int DEST_BIT  = 7;
    localparam int ADDR_MSB  = 6;
    localparam int ADDR_LSB  = 0;

    // Full-word opcodes for the two operand-less returns.
    localparam logic [INSTR_W-1:0] INTERRUPT_RETURN_OP  = 14'h0011;
    localparam logic [INSTR_W-1:0] SUBROUTINE_RETURN_OP = 14'h0010;

    // Group codes in the upper six bits for operand-carrying opcodes.
    localparam logic [GROUP_W-1:0] LITERAL_RETURN_OP     = 6'h35;
    localparam logic [GROUP_W-1:0] ROTATE_LEFT_CARRY_OP  = 6'h0D;
    localparam logic [GROUP_W-1:0] ROTATE_RIGHT_CARRY_OP = 6'h0C;

    // Destination select values.
    localparam logic DEST_ACCUM = 1'b0;
    localparam logic DEST_FILE  = 1'b1;

    // Bit positions.
    localparam int GLOBAL_IRQ_ENABLE_BIT = 7;
    localparam int BYTE_MSB              = 7;
    localparam int BYTE_LSB              = 0;
    localparam int CARRY_BIT             = 0;
    localparam int DIGIT_CARRY_BIT       = 1;
    localparam int ZERO_BIT              = 2;
    localparam int STATUS_W              = 3;

    // Reset values.
    localparam logic [DATA_W-1:0]   ACCUM_RESET    = 8'h00;
    localparam logic [DATA_W-1:0]   INTERRUPT_CONTROL_RESET = 8'h00;
    localparam logic [STATUS_W-1:0] STATUS_RESET   = 3'h0;
    localparam logic [FADDR_W-1:0]  FADDR_RESET    = 7'h00;

    // Cycles taken by a return; rotates take one.
    localparam int RETURN_CYCLES = 2;

    typedef enum logic [1:0] {
        ST_IDLE   = 2'b01,
        ST_SECOND = 2'b10
    } exec_state_type;

endpackage : return_rotate_pkg

`default_nettype wire

// ===== verilog/call_stack.sv
// Purpose: Hardware call stack of return addresses held in flip-flops.
// Assumes: Depth is a power of two; the pointer wraps on overflow or underflow.
// Notes:   Overflow detection is left to the surrounding core.
`default_nettype none

module call_stack #(
    parameter int DEPTH = 16,
    parameter int WIDTH = 15
) (
    input  wire logic             clk_i,        // Instruction clock.
    input  wire logic             rst_i,        // Asynchronous reset, active high.
    input  wire logic             push_i,       // Push a return address.
    input  wire logic [WIDTH-1:0] push_data_i,  // Address to push.
    input  wire logic             pop_i,        // Discard the top entry.
    output logic      [WIDTH-1:0] top_o         // Current top entry.
);

    localparam int PTR_W = $clog2(DEPTH);

    initial begin
        if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin
            $error("call_stack: DEPTH must be a power of two, at least 2");
        end
    end

    logic [WIDTH-1:0] entry_reg [DEPTH];
    logic [PTR_W-1:0] ptr_reg;
    logic [PTR_W-1:0] top_idx;

    // The pointer names the next free slot, so the top sits one below it.
    assign top_idx = ptr_reg - PTR_W'(1);
    assign top_o   = entry_reg[top_idx];

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ptr_reg <= '0;
        end else if (push_i && !pop_i) begin
            ptr_reg <= ptr_reg + PTR_W'(1);
        end else if (pop_i && !push_i) begin
            ptr_reg <= top_idx;
        end
    end

    // A push together with a pop replaces the top entry in place.
    generate
        for (genvar i = 0; i < DEPTH; i++) begin : g_entry
            always_ff @(posedge clk_i or posedge rst_i) begin
                if (rst_i) begin
                    entry_reg[i] <= '0;
                end else if (push_i) begin
                    if (pop_i && top_idx == PTR_W'(i)) begin
                        entry_reg[i] <= push_data_i;
                    end else if (!pop_i && ptr_reg == PTR_W'(i)) begin
                        entry_reg[i] <= push_data_i;
                    end
                end
            end
        end
    endgenerate

endmodule : call_stack

`default_nettype wire

// ===== verilog/return_and_rotate_exec.sv
// Purpose: Executes the three return opcodes and the two rotate-through-carry opcodes.
// Assumes: The core presents the addressed file register value on file_rdata_i with the instruction.
// Notes:   Flags and the interrupt control register are also loadable by the rest of the core.
`default_nettype none

module return_and_rotate_exec #(
    parameter int PC_W        = 15,
    parameter int STACK_DEPTH = 16
) (
    input  wire logic                                 clk_i,           // Instruction clock.
    input  wire logic                                 rst_i,           // Asynchronous reset, active high.
    input  wire logic                                 instr_valid_i,   // Instruction word offered.
    input  wire logic [return_rotate_pkg::INSTR_W-1:0] instr_i,        // Instruction word.
    input  wire logic [return_rotate_pkg::DATA_W-1:0] file_rdata_i,    // Value of the addressed file register.
    input  wire logic                                 push_i,          // Push a return address (call, interrupt).
    input  wire logic [PC_W-1:0]                      push_addr_i,     // Return address to push.
    input  wire logic                                 irq_entry_i,     // Interrupt taken: clear global enable.
    input  wire logic                                 status_we_i,     // Load flags from the core.
    input  wire logic [return_rotate_pkg::STATUS_W-1:0] status_wdata_i, // Flags to load {Z, DC, C}.
    input  wire logic                                 interrupt_control_we_i,    // Load interrupt control register.
    input  wire logic [return_rotate_pkg::DATA_W-1:0] interrupt_control_wdata_i, // Interrupt control value.
    output logic                                      ready_o,         // Ready to take an instruction.
    output logic                                      done_o,          // Instruction completed, one cycle.
    output logic                                      pc_load_o,       // Program counter reloaded, one cycle.
    output logic      [PC_W-1:0]                      pc_o,            // Program counter value.
    output logic      [return_rotate_pkg::DATA_W-1:0] accum_o,         // Accumulator.
    output logic      [return_rotate_pkg::STATUS_W-1:0] status_o,      // Flags {Z, DC, C}.
    output logic      [return_rotate_pkg::DATA_W-1:0] interrupt_control_o, // Interrupt control register.
    output logic                                      file_we_o,       // File register write strobe.
    output logic      [return_rotate_pkg::FADDR_W-1:0] file_addr_o,    // File register write address.
    output logic      [return_rotate_pkg::DATA_W-1:0] file_wdata_o     // File register write data.
);

    initial begin
        if (PC_W < 1 || STACK_DEPTH < 2) begin
            $error("return_and_rotate_exec: PC_W and STACK_DEPTH out of range");
        end
    end

    return_rotate_pkg::exec_state_type state_reg;

    logic                                     ready_reg;
    logic                                     done_reg;
    logic                                     pc_load_reg;
    logic [PC_W-1:0]                          pc_reg;
    logic [return_rotate_pkg::DATA_W-1:0]     accum_reg;
    logic [return_rotate_pkg::STATUS_W-1:0]   status_reg;
    logic [return_rotate_pkg::DATA_W-1:0]     interrupt_control_reg;
    logic                                     file_we_reg;
    logic [return_rotate_pkg::FADDR_W-1:0]    file_addr_reg;
    logic [return_rotate_pkg::DATA_W-1:0]     file_wdata_reg;

    logic                                     accept;
    logic [return_rotate_pkg::GROUP_W-1:0]    group;
    logic                                     is_int_ret;
    logic                                     is_sub_ret;
    logic                                     is_lit_ret;
    logic                                     is_rot_left;
    logic                                     is_rot_right;
    logic                                     is_return;
    logic                                     is_rotate;
    logic                                     dest_sel;
    logic [return_rotate_pkg::DATA_W-1:0]     rot_next;
    logic                                     carry_next;
    logic [PC_W-1:0]                          stack_top;

    assign accept   = instr_valid_i && ready_reg;
    assign group    = instr_i[return_rotate_pkg::GROUP_MSB:return_rotate_pkg::GROUP_LSB];
    assign dest_sel = instr_i[return_rotate_pkg::DEST_BIT];

    assign is_int_ret   = instr_i == return_rotate_pkg::INTERRUPT_RETURN_OP;
    assign is_sub_ret   = instr_i == return_rotate_pkg::SUBROUTINE_RETURN_OP;
    assign is_lit_ret   = group == return_rotate_pkg::LITERAL_RETURN_OP;
    assign is_rot_left  = group == return_rotate_pkg::ROTATE_LEFT_CARRY_OP;
    assign is_rot_right = group == return_rotate_pkg::ROTATE_RIGHT_CARRY_OP;
    assign is_return    = is_int_ret || is_sub_ret || is_lit_ret;
    assign is_rotate    = is_rot_left || is_rot_right;

    // The rotate result and the new carry come from the old carry and the addressed byte.
    always_comb begin
        rot_next   = file_rdata_i;
        carry_next = status_reg[return_rotate_pkg::CARRY_BIT];
        if (is_rot_left) begin
            rot_next   = {file_rdata_i[return_rotate_pkg::BYTE_MSB-1:return_rotate_pkg::BYTE_LSB],
                          status_reg[return_rotate_pkg::CARRY_BIT]};
            carry_next = file_rdata_i[return_rotate_pkg::BYTE_MSB];
        end else if (is_rot_right) begin
            rot_next   = {status_reg[return_rotate_pkg::CARRY_BIT],
                          file_rdata_i[return_rotate_pkg::BYTE_MSB:return_rotate_pkg::BYTE_LSB+1]};
            carry_next = file_rdata_i[return_rotate_pkg::BYTE_LSB];
        end
    end

    call_stack #(
        .DEPTH (STACK_DEPTH),
        .WIDTH (PC_W)
    ) u_stack (
        .clk_i       (clk_i),
        .rst_i       (rst_i),
        .push_i      (push_i),
        .push_data_i (push_addr_i),
        .pop_i       (accept && is_return),
        .top_o       (stack_top)
    );

    // A return holds the pipe for one extra cycle while the fetch refills.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_reg <= return_rotate_pkg::ST_IDLE;
            ready_reg <= 1'b1;
        end else begin
            unique case (state_reg)
                return_rotate_pkg::ST_IDLE: begin
                    if (accept && is_return) begin
                        state_reg <= return_rotate_pkg::ST_SECOND;
                        ready_reg <= 1'b0;
                    end
                end
                return_rotate_pkg::ST_SECOND: begin
                    state_reg <= return_rotate_pkg::ST_IDLE;
                    ready_reg <= 1'b1;
                end
                default: begin
                    state_reg <= return_rotate_pkg::ST_IDLE;
                    ready_reg <= 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            done_reg <= 1'b0;
        end else begin
            done_reg <= (accept && is_rotate) || (state_reg == return_rotate_pkg::ST_SECOND);
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            pc_reg      <= '0;
            pc_load_reg <= 1'b0;
        end else begin
            pc_load_reg <= accept && is_return;
            if (accept && is_return) begin
                pc_reg <= stack_top;
            end
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            accum_reg <= return_rotate_pkg::ACCUM_RESET;
        end else if (accept && is_lit_ret) begin
            accum_reg <= instr_i[return_rotate_pkg::LIT_MSB:return_rotate_pkg::LIT_LSB];
        end else if (accept && is_rotate && dest_sel == return_rotate_pkg::DEST_ACCUM) begin
            accum_reg <= rot_next;
        end
    end

    // Only carry follows a rotate; zero and digit carry keep their value.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            status_reg <= return_rotate_pkg::STATUS_RESET;
        end else begin
            if (status_we_i) begin
                status_reg <= status_wdata_i;
            end
            if (accept && is_rotate) begin
                status_reg[return_rotate_pkg::CARRY_BIT] <= carry_next;
            end
        end
    end

    // The return sets the global enable even when an interrupt entry clears it in the same cycle.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            interrupt_control_reg <= return_rotate_pkg::INTERRUPT_CONTROL_RESET;
        end else begin
            if (interrupt_control_we_i) begin
                interrupt_control_reg <= interrupt_control_wdata_i;
            end
            if (irq_entry_i) begin
                interrupt_control_reg[return_rotate_pkg::GLOBAL_IRQ_ENABLE_BIT] <= 1'b0;
            end
            if (accept && is_int_ret) begin
                interrupt_control_reg[return_rotate_pkg::GLOBAL_IRQ_ENABLE_BIT] <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            file_we_reg    <= 1'b0;
            file_addr_reg  <= return_rotate_pkg::FADDR_RESET;
            file_wdata_reg <= return_rotate_pkg::ACCUM_RESET;
        end else begin
            file_we_reg <= accept && is_rotate && dest_sel == return_rotate_pkg::DEST_FILE;
            if (accept && is_rotate) begin
                file_addr_reg  <= instr_i[return_rotate_pkg::ADDR_MSB:return_rotate_pkg::ADDR_LSB];
                file_wdata_reg <= rot_next;
            end
        end
    end

    assign ready_o             = ready_reg;
    assign done_o              = done_reg;
    assign pc_load_o           = pc_load_reg;
    assign pc_o                = pc_reg;
    assign accum_o             = accum_reg;
    assign status_o            = status_reg;
    assign interrupt_control_o = interrupt_control_reg;
    assign file_we_o           = file_we_reg;
    assign file_addr_o         = file_addr_reg;
    assign file_wdata_o        = file_wdata_reg;

endmodule : return_and_rotate_exec

`default_nettype wire
